// ---- rtl/dsos_map.vh ----
// Register map, field positions, reset values and timing counts of the drive
// status output selector. Included by the interrupt and top files of the block; the pulse generator does without it.
`ifndef DSOS_MAP_VH
`define DSOS_MAP_VH

// Register offsets on the 8-bit register port.
`define DSOS_ADDR_FUNC      8'h00
`define DSOS_ADDR_ZERO_FREQ 8'h04
`define DSOS_ADDR_TGT_LEN   8'h08
`define DSOS_ADDR_CUTOFF    8'h0C
`define DSOS_ADDR_STATE     8'h10
`define DSOS_ADDR_IRQ_STAT  8'h14
`define DSOS_ADDR_IRQ_EN    8'h18
`define DSOS_ADDR_IRQ_CLR   8'h1C

// Widths.
`define DSOS_ADDR_W   8
`define DSOS_DATA_W   32
`define DSOS_FUNC_W   5
`define DSOS_FREQ_W   16
`define DSOS_COND_W   10
`define DSOS_IRQ_W    4

// Reset values.
`define DSOS_FUNC_RST      5'h00
`define DSOS_ZERO_FREQ_RST 16'h0000
`define DSOS_TGT_LEN_RST   32'hFFFFFFFF
`define DSOS_CUTOFF_RST    32'hFFFFFFFF
`define DSOS_IRQ_EN_RST    4'h0

// Function codes of the output terminal.
`define DSOS_FC_ZERO_RUN   5'h0A
`define DSOS_FC_STAGE_DONE 5'h0B
`define DSOS_FC_CYCLE_DONE 5'h0C
`define DSOS_FC_LEN_REACH  5'h0F
`define DSOS_FC_READY      5'h10
`define DSOS_FC_FAULT      5'h11
`define DSOS_FC_RSVD_18    5'h12
`define DSOS_FC_TIME_REACH 5'h13
`define DSOS_FC_FWD_RUN    5'h14
`define DSOS_FC_REV_RUN    5'h15
`define DSOS_FC_RSVD_22    5'h16
`define DSOS_FC_SLEEP      5'h17

// Condition vector bit positions, also the state register layout.
`define DSOS_C_ZERO  0
`define DSOS_C_STAGE 1
`define DSOS_C_CYCLE 2
`define DSOS_C_LEN   3
`define DSOS_C_READY 4
`define DSOS_C_FAULT 5
`define DSOS_C_TIME  6
`define DSOS_C_FWD   7
`define DSOS_C_REV   8
`define DSOS_C_SLEEP 9
`define DSOS_S_TERM  10

// Interrupt bit positions.
`define DSOS_I_STAGE 0
`define DSOS_I_CYCLE 1
`define DSOS_I_TERM  2
`define DSOS_I_FAULT 3

// Pulse timing.
`define DSOS_PULSE_MS 250
`define DSOS_CLK_KHZ  250000

`endif

// ---- rtl/dsos_pulse.v ----
// One-shot pulse generator: a trigger starts a pulse of PULSE_CYC cycles.
// Assumes a single clock and a one-cycle trigger from the sequencer.
`timescale 1ns/1ps

module dsos_pulse #(
    parameter PULSE_CYC = 62500000
) (
    // Clock and reset
    input  wire i_clk,
    input  wire i_rst,
    // Trigger and pulse
    input  wire i_trig,
    output wire o_pulse
);

localparam [1:0]  ST_IDLE = 2'b01;
localparam [1:0]  ST_RUN  = 2'b10;
localparam [31:0] LAST    = PULSE_CYC - 1;

reg [1:0]  state_r;
reg [31:0] cnt_r;

////////////////////////////////////////////////////////////////////////////////
// A trigger during a pulse restarts the count, so back-to-back stage ends
// stretch the pulse rather than merging two indications into a short gap.
always @(posedge i_clk) begin
    if (i_rst) begin
        state_r <= ST_IDLE;
        cnt_r   <= 32'h00000000;
    end else begin
        case (state_r)
            ST_IDLE: begin
                if (i_trig) begin
                    state_r <= ST_RUN;
                    cnt_r   <= 32'h00000000;
                end
            end
            ST_RUN: begin
                if (i_trig) begin
                    cnt_r <= 32'h00000000;
                end else if (cnt_r == LAST) begin
                    state_r <= ST_IDLE;
                    cnt_r   <= 32'h00000000;
                end else begin
                    cnt_r <= cnt_r + 32'h00000001;
                end
            end
            default: begin
                state_r <= ST_IDLE;
                cnt_r   <= 32'h00000000;
            end
        endcase
    end
end

assign o_pulse = state_r[1];

endmodule

// ---- rtl/dsos_irq.v ----
// Sticky interrupt status with enable and write-one-to-clear registers.
// Assumes events are one-cycle pulses in the system clock domain.
`timescale 1ns/1ps
`include "dsos_map.vh"

module dsos_irq (
    // Clock and reset
    input  wire                   i_clk,
    input  wire                   i_rst,
    // Events
    input  wire [`DSOS_IRQ_W-1:0] i_evt,
    // Register writes
    input  wire                   i_en_wr,
    input  wire                   i_clr_wr,
    input  wire [`DSOS_IRQ_W-1:0] i_wdata,
    // Status and interrupt
    output wire [`DSOS_IRQ_W-1:0] o_stat,
    output wire [`DSOS_IRQ_W-1:0] o_en,
    output wire                   o_irq
);

reg [`DSOS_IRQ_W-1:0] stat_r;
reg [`DSOS_IRQ_W-1:0] en_r;

////////////////////////////////////////////////////////////////////////////////
// A new event wins over a clear written in the same cycle.
always @(posedge i_clk) begin
    if (i_rst) begin
        stat_r <= {`DSOS_IRQ_W{1'b0}};
        en_r   <= `DSOS_IRQ_EN_RST;
    end else begin
        if (i_clr_wr) begin
            stat_r <= (stat_r & ~i_wdata) | i_evt;
        end else begin
            stat_r <= stat_r | i_evt;
        end
        if (i_en_wr) begin
            en_r <= i_wdata;
        end
    end
end

assign o_stat = stat_r;
assign o_en   = en_r;
assign o_irq  = |(stat_r & en_r);

endmodule

// ---- rtl/dsos_top.v ----
// Status output selector of a variable-frequency drive: picks the condition
// that drives one output terminal from a function code held in a register.
// Assumes drive status inputs synchronous to i_clk and one-cycle stage and
// cycle completion strobes from the sequencer.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "dsos_map.vh"

module dsos_top #(
    parameter PULSE_CYC = `DSOS_PULSE_MS * `DSOS_CLK_KHZ
) (
    // Clock and reset
    input  wire                   i_clk,
    input  wire                   i_rst,
    // Register port
    input  wire [`DSOS_ADDR_W-1:0] i_addr,
    input  wire [`DSOS_DATA_W-1:0] i_wdata,
    input  wire                   i_wr,
    input  wire                   i_rd,
    output wire [`DSOS_DATA_W-1:0] o_rdata,
    // Drive run status
    input  wire                   i_running,
    input  wire                   i_reverse,
    input  wire [`DSOS_FREQ_W-1:0] i_out_freq,
    // Sequencer strobes
    input  wire                   i_stage_done,
    input  wire                   i_cycle_done,
    // Length and run time monitors
    input  wire [31:0]            i_actual_length_monitor,
    input  wire [31:0]            i_accumulated_run_time_monitor,
    // Protection status
    input  wire                   i_fault,
    input  wire                   i_bus_volt_ok,
    input  wire                   i_run_inhibit,
    // Water supply application
    input  wire                   i_water_app,
    input  wire                   i_sleep,
    // Terminal and interrupt
    output wire                   o_term_on,
    output wire                   o_irq
);

////////////////////////////////////////////////////////////////////////////////
// Helpers.

// Unsigned compare shared by every reached-type condition.
function at_least;
    input [31:0] val;
    input [31:0] lim;
    begin
        at_least = (val >= lim);
    end
endfunction

// Full address match; the port decodes no aliases.
function hit;
    input [`DSOS_ADDR_W-1:0] addr;
    input [`DSOS_ADDR_W-1:0] offs;
    begin
        hit = (addr == offs);
    end
endfunction

function [31:0] widen_freq;
    input [`DSOS_FREQ_W-1:0] freq;
    begin
        widen_freq = {{(32-`DSOS_FREQ_W){1'b0}}, freq};
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Declarations.

reg  [`DSOS_FUNC_W-1:0] func_r;
reg  [`DSOS_FREQ_W-1:0] zero_freq_range_setting_r;
reg  [31:0]             target_length_setting_r;
reg  [31:0]             run_cutoff_time_setting_r;
reg  [`DSOS_DATA_W-1:0] rdata_r;
reg  [`DSOS_DATA_W-1:0] rdata_nxt;
reg                     term_r;
reg                     term_nxt;
reg                     fault_d_r;
reg                     term_d_r;
reg  [`DSOS_COND_W-1:0] cond;

wire                    stage_pulse;
wire                    cycle_pulse;
wire [`DSOS_IRQ_W-1:0]  irq_evt;
wire [`DSOS_IRQ_W-1:0]  irq_stat;
wire [`DSOS_IRQ_W-1:0]  irq_en;
wire                    wr_func;
wire                    wr_zero;
wire                    wr_len;
wire                    wr_cutoff;
wire                    wr_irq_en;
wire                    wr_irq_clr;
wire                    term_rise;
wire                    fault_rise;

////////////////////////////////////////////////////////////////////////////////
// Register writes. Writes to read-only or unmapped offsets are ignored.
// Upper write data bits of the narrow settings are dropped. Settings keep
// their value through a fault; only reset restores the defaults.

assign wr_func    = i_wr & hit(i_addr, `DSOS_ADDR_FUNC);
assign wr_zero    = i_wr & hit(i_addr, `DSOS_ADDR_ZERO_FREQ);
assign wr_len     = i_wr & hit(i_addr, `DSOS_ADDR_TGT_LEN);
assign wr_cutoff  = i_wr & hit(i_addr, `DSOS_ADDR_CUTOFF);
assign wr_irq_en  = i_wr & hit(i_addr, `DSOS_ADDR_IRQ_EN);
assign wr_irq_clr = i_wr & hit(i_addr, `DSOS_ADDR_IRQ_CLR);

always @(posedge i_clk) begin
    if (i_rst) begin
        func_r                    <= `DSOS_FUNC_RST;
        zero_freq_range_setting_r <= `DSOS_ZERO_FREQ_RST;
        target_length_setting_r   <= `DSOS_TGT_LEN_RST;
        run_cutoff_time_setting_r <= `DSOS_CUTOFF_RST;
    end else begin
        if (wr_func) begin
            func_r <= i_wdata[`DSOS_FUNC_W-1:0];
        end
        if (wr_zero) begin
            zero_freq_range_setting_r <= i_wdata[`DSOS_FREQ_W-1:0];
        end
        if (wr_len) begin
            target_length_setting_r <= i_wdata;
        end
        if (wr_cutoff) begin
            run_cutoff_time_setting_r <= i_wdata;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Completion pulses. Both run all the time so that changing the function
// code mid-pulse shows the remainder of a pulse already under way.

dsos_pulse #(
    .PULSE_CYC (PULSE_CYC)
) u_stage_pulse (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_trig  (i_stage_done),
    .o_pulse (stage_pulse)
);

dsos_pulse #(
    .PULSE_CYC (PULSE_CYC)
) u_cycle_pulse (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_trig  (i_cycle_done),
    .o_pulse (cycle_pulse)
);

////////////////////////////////////////////////////////////////////////////////
// Condition vector.
// All comparisons are unsigned. The all-ones reset value of the length and
// cutoff settings keeps those two conditions false until software programs
// them, unless a monitor itself sits at its maximum.

always @* begin
    cond = {`DSOS_COND_W{1'b0}};
    cond[`DSOS_C_ZERO]  = i_running &
        at_least(widen_freq(zero_freq_range_setting_r), widen_freq(i_out_freq));
    cond[`DSOS_C_STAGE] = stage_pulse;
    cond[`DSOS_C_CYCLE] = cycle_pulse;
    cond[`DSOS_C_LEN]   = at_least(i_actual_length_monitor, target_length_setting_r);
    cond[`DSOS_C_READY] = ~i_fault & i_bus_volt_ok & ~i_run_inhibit;
    cond[`DSOS_C_FAULT] = i_fault;
    cond[`DSOS_C_TIME]  = at_least(i_accumulated_run_time_monitor, run_cutoff_time_setting_r);
    cond[`DSOS_C_FWD]   = i_running & ~i_reverse;
    cond[`DSOS_C_REV]   = i_running & i_reverse;
    cond[`DSOS_C_SLEEP] = i_water_app & i_sleep;
end

////////////////////////////////////////////////////////////////////////////////
// Selector. Codes served elsewhere and reserved codes leave the terminal off.
// Codes 0 to 9, 13, 14 and 24 upwards fall into the default branch.

always @* begin
    case (func_r)
        `DSOS_FC_ZERO_RUN:   term_nxt = cond[`DSOS_C_ZERO];
        `DSOS_FC_STAGE_DONE: term_nxt = cond[`DSOS_C_STAGE];
        `DSOS_FC_CYCLE_DONE: term_nxt = cond[`DSOS_C_CYCLE];
        `DSOS_FC_LEN_REACH:  term_nxt = cond[`DSOS_C_LEN];
        `DSOS_FC_READY:      term_nxt = cond[`DSOS_C_READY];
        `DSOS_FC_FAULT:      term_nxt = cond[`DSOS_C_FAULT];
        `DSOS_FC_TIME_REACH: term_nxt = cond[`DSOS_C_TIME];
        `DSOS_FC_FWD_RUN:    term_nxt = cond[`DSOS_C_FWD];
        `DSOS_FC_REV_RUN:    term_nxt = cond[`DSOS_C_REV];
        `DSOS_FC_SLEEP:      term_nxt = cond[`DSOS_C_SLEEP];
        `DSOS_FC_RSVD_18:    term_nxt = 1'b0;
        `DSOS_FC_RSVD_22:    term_nxt = 1'b0;
        default:             term_nxt = 1'b0;
    endcase
end

// The terminal is registered so that it never glitches while the code or
// the comparator inputs change; the cost is one cycle of latency.
always @(posedge i_clk) begin
    if (i_rst) begin
        term_r    <= 1'b0;
        term_d_r  <= 1'b0;
        fault_d_r <= 1'b0;
    end else begin
        term_r    <= term_nxt;
        term_d_r  <= term_r;
        fault_d_r <= i_fault;
    end
end

assign o_term_on = term_r;

////////////////////////////////////////////////////////////////////////////////
// Interrupts. The terminal event follows the registered terminal, so it reports
// what the load saw, one cycle after the condition. A fault event is taken on
// the first cycle in which the fault input is seen high.

assign term_rise  = term_r & ~term_d_r;
assign fault_rise = i_fault & ~fault_d_r;

assign irq_evt[`DSOS_I_STAGE] = i_stage_done;
assign irq_evt[`DSOS_I_CYCLE] = i_cycle_done;
assign irq_evt[`DSOS_I_TERM]  = term_rise;
assign irq_evt[`DSOS_I_FAULT] = fault_rise;

dsos_irq u_irq (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_evt    (irq_evt),
    .i_en_wr  (wr_irq_en),
    .i_clr_wr (wr_irq_clr),
    .i_wdata  (i_wdata[`DSOS_IRQ_W-1:0]),
    .o_stat   (irq_stat),
    .o_en     (irq_en),
    .o_irq    (o_irq)
);

////////////////////////////////////////////////////////////////////////////////
// Read path. Data stand for exactly one cycle after the read strobe and read
// as zero otherwise, including for unmapped and write-only offsets.

always @* begin
    rdata_nxt = {`DSOS_DATA_W{1'b0}};
    if (i_rd) begin
        case (i_addr)
            `DSOS_ADDR_FUNC: begin
                rdata_nxt[`DSOS_FUNC_W-1:0] = func_r;
            end
            `DSOS_ADDR_ZERO_FREQ: begin
                rdata_nxt[`DSOS_FREQ_W-1:0] = zero_freq_range_setting_r;
            end
            `DSOS_ADDR_TGT_LEN: begin
                rdata_nxt = target_length_setting_r;
            end
            `DSOS_ADDR_CUTOFF: begin
                rdata_nxt = run_cutoff_time_setting_r;
            end
            // Pulse bits show the internal pulse, one cycle ahead of the terminal.
            `DSOS_ADDR_STATE: begin
                rdata_nxt[`DSOS_COND_W-1:0] = cond;
                rdata_nxt[`DSOS_S_TERM]     = term_r;
            end
            `DSOS_ADDR_IRQ_STAT: begin
                rdata_nxt[`DSOS_IRQ_W-1:0] = irq_stat;
            end
            `DSOS_ADDR_IRQ_EN: begin
                rdata_nxt[`DSOS_IRQ_W-1:0] = irq_en;
            end
            // The clear offset is write-only and reads as zero.
            `DSOS_ADDR_IRQ_CLR: begin
                rdata_nxt = {`DSOS_DATA_W{1'b0}};
            end
            default: begin
                rdata_nxt = {`DSOS_DATA_W{1'b0}};
            end
        endcase
    end
end

always @(posedge i_clk) begin
    if (i_rst) begin
        rdata_r <= {`DSOS_DATA_W{1'b0}};
    end else begin
        rdata_r <= rdata_nxt;
    end
end

assign o_rdata = rdata_r;

endmodule

// ---- test/dsos_properties.sv ----
// Checker for the status output selector: terminal level against the selected code.
// Assumes it is bound to dsos_top and sees only that module's ports.
`timescale 1ns/1ps

module dsos_chk #(
    parameter PULSE_CYC = 20
) (
    input wire        i_clk,
    input wire        i_rst,
    input wire [7:0]  i_addr,
    input wire [31:0] i_wdata,
    input wire        i_wr,
    input wire        i_running,
    input wire        i_reverse,
    input wire [15:0] i_out_freq,
    input wire        i_stage_done,
    input wire        i_cycle_done,
    input wire [31:0] i_actual_length_monitor,
    input wire [31:0] i_accumulated_run_time_monitor,
    input wire        i_fault,
    input wire        i_bus_volt_ok,
    input wire        i_run_inhibit,
    input wire        i_water_app,
    input wire        i_sleep,
    input wire        o_term_on
);
    // Shadow copies of the settings; fp_r is the code that drove the current output.
    reg [4:0]  fn_r;
    reg [4:0]  fp_r;
    reg [15:0] zf_r;
    reg [31:0] tl_r;
    reg [31:0] ct_r;
    reg [31:0] sc_r;
    reg [31:0] cc_r;
    always @(posedge i_clk) begin
        if (i_rst) begin
            fn_r <= 5'h00;
            fp_r <= 5'h00;
            zf_r <= 16'h0000;
            tl_r <= 32'hFFFFFFFF;
            ct_r <= 32'hFFFFFFFF;
            sc_r <= 32'h0;
            cc_r <= 32'h0;
        end else begin
            fp_r <= fn_r;
            if (i_wr && i_addr == 8'h00) fn_r <= i_wdata[4:0];
            if (i_wr && i_addr == 8'h04) zf_r <= i_wdata[15:0];
            if (i_wr && i_addr == 8'h08) tl_r <= i_wdata;
            if (i_wr && i_addr == 8'h0C) ct_r <= i_wdata;
            sc_r <= i_stage_done ? 32'h1 : (sc_r != 0 && sc_r <= PULSE_CYC) ? sc_r + 32'h1 : 32'h0;
            cc_r <= i_cycle_done ? 32'h1 : (cc_r != 0 && cc_r <= PULSE_CYC) ? cc_r + 32'h1 : 32'h0;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    zero_run_a: assert property (fp_r == 5'h0A |-> o_term_on == $past(i_running && i_out_freq <= zf_r))
        else $error("zero frequency run level wrong");
    stage_pulse_a: assert property (fp_r == 5'h0B && sc_r != 1 |-> o_term_on == (sc_r >= 2 && sc_r <= PULSE_CYC + 1))
        else $error("stage pulse wrong");
    cycle_pulse_a: assert property (fp_r == 5'h0C && cc_r != 1 |-> o_term_on == (cc_r >= 2 && cc_r <= PULSE_CYC + 1))
        else $error("cycle pulse wrong");
    len_reach_a: assert property (fp_r == 5'h0F |-> o_term_on == $past(i_actual_length_monitor >= tl_r))
        else $error("length reached level wrong");
    ready_run_a: assert property (fp_r == 5'h10 |-> o_term_on == $past(!i_fault && i_bus_volt_ok && !i_run_inhibit))
        else $error("ready level wrong");
    fault_level_a: assert property (fp_r == 5'h11 |-> o_term_on == $past(i_fault)) else $error("fault level wrong");
    time_reach_a: assert property (fp_r == 5'h13 |-> o_term_on == $past(i_accumulated_run_time_monitor >= ct_r))
        else $error("run time level wrong");
    fwd_run_a: assert property (fp_r == 5'h14 |-> o_term_on == $past(i_running && !i_reverse))
        else $error("forward level wrong");
    rev_run_a: assert property (fp_r == 5'h15 |-> o_term_on == $past(i_running && i_reverse))
        else $error("reverse level wrong");
    sleep_ind_a: assert property (fp_r == 5'h17 |-> o_term_on == $past(i_water_app && i_sleep))
        else $error("sleep level wrong");
    rsvd_off_a: assert property (fp_r == 5'h12 || fp_r == 5'h16 |-> !o_term_on) else $error("reserved code drives");
endmodule

bind dsos_top dsos_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_running(i_running), .i_reverse(i_reverse), .i_out_freq(i_out_freq),
    .i_stage_done(i_stage_done), .i_cycle_done(i_cycle_done),
    .i_actual_length_monitor(i_actual_length_monitor),
    .i_accumulated_run_time_monitor(i_accumulated_run_time_monitor),
    .i_fault(i_fault), .i_bus_volt_ok(i_bus_volt_ok), .i_run_inhibit(i_run_inhibit),
    .i_water_app(i_water_app), .i_sleep(i_sleep), .o_term_on(o_term_on));

// ---- test/dsos_load.sv ----
// Load on the output terminal: measures each on period in clock cycles.
// Assumes the terminal level is sampled on the system clock.
`timescale 1ns/1ps

module dsos_load (
    input  wire        i_clk,
    input  wire        i_drive,
    output reg  [31:0] o_width,
    output reg  [31:0] o_count
);
    reg [31:0] run_r;
    initial begin
        run_r = 32'h0;
        o_width = 32'h0;
        o_count = 32'h0;
    end
    // A period is reported when it ends, so a pulse still running is not counted.
    always @(posedge i_clk) begin
        if (i_drive) begin
            run_r <= run_r + 32'h1;
        end else if (run_r != 32'h0) begin
            o_width <= run_r;
            o_count <= o_count + 32'h1;
            run_r <= 32'h0;
        end
    end
endmodule

// ---- test/tb.sv ----
// Testbench of the status output selector with a terminal load model.
// Assumes the checker is bound to dsos_top by its own file.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks = checks + 1; if ((g) !== (e)) begin err_count = err_count + 1; \
    $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end

module tb;
    localparam PC = 20;
    reg         i_clk, i_rst, i_wr, i_rd, i_running, i_reverse, i_stage_done, i_cycle_done;
    reg         i_fault, i_bus_volt_ok, i_run_inhibit, i_water_app, i_sleep;
    reg  [7:0]  i_addr;
    reg  [15:0] i_out_freq;
    reg  [31:0] i_wdata, alen, artm, rv;
    wire [31:0] o_rdata, w_width, w_count;
    wire        o_term_on, o_irq;
    integer     err_count, checks, k;

    dsos_top #(.PULSE_CYC(PC)) i_dsos_top (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_running(i_running),
        .i_reverse(i_reverse), .i_out_freq(i_out_freq), .i_stage_done(i_stage_done),
        .i_cycle_done(i_cycle_done), .i_actual_length_monitor(alen),
        .i_accumulated_run_time_monitor(artm), .i_fault(i_fault), .i_bus_volt_ok(i_bus_volt_ok),
        .i_run_inhibit(i_run_inhibit), .i_water_app(i_water_app), .i_sleep(i_sleep),
        .o_term_on(o_term_on), .o_irq(o_irq));
    dsos_load i_dsos_load (.i_clk(i_clk), .i_drive(o_term_on), .o_width(w_width), .o_count(w_count));

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////
    task close_out;
        begin
            $display("checks %0d mismatches %0d", checks, err_count);
            if (err_count == 0 && checks > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge i_clk);
            i_addr <= a;
            i_wdata <= d;
            i_wr <= 1'b1;
            @(posedge i_clk);
            i_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            @(posedge i_clk);
            i_addr <= a;
            i_rd <= 1'b1;
            @(posedge i_clk);
            i_rd <= 1'b0;
            #1;
            `CHK("rdata", e, o_rdata)
        end
    endtask
    task sel(input [4:0] c);
        wr(8'h00, {27'h0, c});
    endtask
    task tchk(input e);
        begin
            @(posedge i_clk);
            #1;
            `CHK("term", e, o_term_on)
        end
    endtask
    // One strobe of the sequencer: stage when s is high, cycle otherwise.
    task pls(input s);
        begin
            @(posedge i_clk);
            i_stage_done <= s;
            i_cycle_done <= !s;
            @(posedge i_clk);
            i_stage_done <= 1'b0;
            i_cycle_done <= 1'b0;
        end
    endtask
    ////////////////////////////////////////////////////////////
    task t_regs;
        begin
            rd(8'h00, 32'h0);
            rd(8'h04, 32'h0);
            rd(8'h08, 32'hFFFFFFFF);
            rd(8'h0C, 32'hFFFFFFFF);
            rd(8'h18, 32'h0);
            rd(8'h10, 32'h10);
            rd(8'h14, 32'h0);
            rd(8'h1C, 32'h0);
            rd(8'h20, 32'h0);
            tchk(1'b0);
        end
    endtask
    task t_zero;
        begin
            wr(8'h04, 32'h64);
            sel(5'h0A);
            rd(8'h04, 32'h64);
            @(posedge i_clk);
            i_running <= 1'b1;
            i_out_freq <= 16'h0064;
            tchk(1'b1);
            @(posedge i_clk);
            i_out_freq <= 16'h0065;
            tchk(1'b0);
            @(posedge i_clk);
            i_out_freq <= 16'h0000;
            i_running <= 1'b0;
            tchk(1'b0);
        end
    endtask
    task t_reach;
        begin
            wr(8'h08, 32'h32);
            sel(5'h0F);
            @(posedge i_clk);
            alen <= 32'h31;
            tchk(1'b0);
            @(posedge i_clk);
            alen <= 32'h32;
            tchk(1'b1);
            wr(8'h0C, 32'h7);
            sel(5'h13);
            @(posedge i_clk);
            artm <= 32'h6;
            tchk(1'b0);
            @(posedge i_clk);
            artm <= 32'h7;
            tchk(1'b1);
        end
    endtask
    task t_ready;
        begin
            sel(5'h10);
            tchk(1'b1);
            @(posedge i_clk);
            i_run_inhibit <= 1'b1;
            tchk(1'b0);
            @(posedge i_clk);
            i_run_inhibit <= 1'b0;
            i_bus_volt_ok <= 1'b0;
            tchk(1'b0);
            @(posedge i_clk);
            i_bus_volt_ok <= 1'b1;
            i_fault <= 1'b1;
            tchk(1'b0);
            sel(5'h11);
            tchk(1'b1);
            @(posedge i_clk);
            i_fault <= 1'b0;
            tchk(1'b0);
        end
    endtask
    task t_state;
        begin
            sel(5'h14);
            @(posedge i_clk);
            i_running <= 1'b1;
            tchk(1'b1);
            @(posedge i_clk);
            i_reverse <= 1'b1;
            tchk(1'b0);
            sel(5'h15);
            tchk(1'b1);
            sel(5'h17);
            @(posedge i_clk);
            i_water_app <= 1'b1;
            tchk(1'b0);
            @(posedge i_clk);
            i_sleep <= 1'b1;
            tchk(1'b1);
            @(posedge i_clk);
            i_fault <= 1'b1;
            i_water_app <= 1'b0;
            tchk(1'b0);
            @(posedge i_clk);
            i_water_app <= 1'b1;
            // The zero, length, time, fault, reverse and sleep conditions are now true; every default and reserved code must keep the terminal off.
            for (k = 0; k < 32; k = k + 1) begin
                if (32'hFF4463FF >> k & 1) begin
                    sel(k[4:0]);
                    tchk(1'b0);
                end
            end
            @(posedge i_clk);
            i_running <= 1'b0;
            i_fault <= 1'b0;
            i_water_app <= 1'b0;
        end
    endtask
    task t_pulse;
        begin
            sel(5'h0B);
            pls(1'b1);
            repeat (PC + 4) @(posedge i_clk);
            `CHK("width", PC, w_width)
            pls(1'b1);
            repeat (3) @(posedge i_clk);
            pls(1'b1);
            repeat (PC + 6) @(posedge i_clk);
            `CHK("width", PC + 5, w_width)
            rv = w_count;
            pls(1'b0);
            repeat (PC + 4) @(posedge i_clk);
            `CHK("count", rv, w_count)
            sel(5'h0C);
            pls(1'b1);
            pls(1'b0);
            repeat (PC + 4) @(posedge i_clk);
            `CHK("width", PC, w_width)
            `CHK("count", rv + 1, w_count)
        end
    endtask
    task t_irq;
        begin
            sel(5'h00);
            wr(8'h18, 32'h0);
            wr(8'h1C, 32'hF);
            pls(1'b1);
            rd(8'h14, 32'h1);
            `CHK("irq", 1'b0, o_irq)
            wr(8'h18, 32'h1);
            #1;
            `CHK("irq", 1'b1, o_irq)
            wr(8'h1C, 32'h1);
            pls(1'b0);
            rd(8'h14, 32'h2);
            `CHK("irq", 1'b0, o_irq)
            sel(5'h11);
            @(posedge i_clk);
            i_fault <= 1'b1;
            // The terminal event lands one edge after the fault event.
            @(posedge i_clk);
            rd(8'h14, 32'hE);
            wr(8'h18, 32'h8);
            #1;
            `CHK("irq", 1'b1, o_irq)
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #100000;
        err_count = err_count + 1;
        close_out;
    end
    initial begin
        err_count = 0;
        checks = 0;
        i_rst = 1'b1;
        {i_wr, i_rd, i_running, i_reverse, i_stage_done, i_cycle_done} = 6'h00;
        {i_fault, i_run_inhibit, i_water_app, i_sleep} = 4'h0;
        i_bus_volt_ok = 1'b1;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        i_out_freq = 16'h0000;
        alen = 32'h0;
        artm = 32'h0;
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        t_regs;
        t_zero;
        t_reach;
        t_ready;
        t_state;
        t_pulse;
        t_irq;
        close_out;
    end
endmodule
